// >>> pkg/trap_status_pkg.sv
package trap_status_pkg;

	// =====================================================
	// Register map (byte addresses, one word each)
	localparam logic [7:0] SOFT_TRAP_FLAGS_OFS = 8'h00;
	localparam logic [7:0] HARD_TRAP_FLAGS_OFS = 8'h04;
	localparam logic [7:0] VECTOR_STATUS_OFS = 8'h08;
	localparam logic [7:0] VECTOR_CTRL_OFS = 8'h0C;

	// =====================================================
	// Soft trap flag positions
	localparam int NET_ADDR_FAULT_BIT = 9;
	localparam int NVM_ADDR_FAULT_BIT = 8;
	localparam int DMA_ADDR_FAULT_BIT = 5;
	localparam int LOOP_OVERFLOW_BIT = 4;
	localparam int AUX_LOCK_LOSS_BIT = 0;
	localparam logic [15:0] SOFT_IMPL_MASK = 16'h0331;

	// =====================================================
	// Hard trap flag positions
	localparam int ECC_DOUBLE_BIT = 1;
	localparam int SOFT_MADE_HARD_BIT = 0;
	localparam logic [15:0] HARD_IMPL_MASK = 16'h0003;

	// =====================================================
	// Vector status layout
	localparam int LIVE_SELECT_BIT = 13;
	localparam int LEVEL_LSB = 8;
	localparam int CTRL_LIVE_BIT = 0;
	localparam logic [15:0] FLAGS_RESET = 16'h0000;
	localparam logic [7:0] VECTOR_RESET = 8'h00;
	localparam logic [3:0] LEVEL_RESET = 4'h0;

	// =====================================================
	// Vector codes; 5, 7 and 255 are never produced
	localparam logic [7:0] VEC_OSC_FAIL = 8'h00;
	localparam logic [7:0] VEC_ADDR_ERR = 8'h01;
	localparam logic [7:0] VEC_HARD_TRAP = 8'h02;
	localparam logic [7:0] VEC_STACK_ERR = 8'h03;
	localparam logic [7:0] VEC_MATH_ERR = 8'h04;
	localparam logic [7:0] VEC_SOFT_TRAP = 8'h06;
	localparam logic [7:0] VEC_IRQ_BASE = 8'h08;
	localparam logic [7:0] VEC_RSVD_A = 8'h05;
	localparam logic [7:0] VEC_RSVD_B = 8'h07;
	localparam logic [7:0] VEC_RSVD_C = 8'hFF;
	localparam int IRQ_COUNT = 16;

endpackage

// >>> hw/soft_trap_status.sv
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/100ps

// Functional notes
// R1 - Network controller address error sets soft flag bit 9.
// R2 - Memory address error sets soft flag bit 8.
// R3 - DMA address error sets soft flag bit 5.
// R4 - Loop stack overflow sets soft flag bit 4.
// R5 - Auxiliary clock lock loss sets soft flag bit 0.
// R6 - Soft register bits 15-10, 7-6, 3-1 read zero, ignore writes.
// R7 - ECC double-bit error sets hard flag bit 1.
// R8 - Software generated hard trap sets hard flag bit 0.
// R9 - Hard register bits 15-2 read zero.
// R10 - Live select high: vector field shows encoder output continuously.
// R11 - Live select low: vector latched at each acknowledge, held until next.
// R12 - Bits 11-8 of status report new priority level 0 to 15.
// R13 - Codes: 0 osc, 1 addr, 2 hard, 3 stack, 4 math, 6 soft, 8+ irq.
// R14 - Codes 5, 7 and 255 are never produced.
// R15 - Flags stay set until software writes zero to them.
// R16 - Status register reads zero after reset; writes do not change it.
module soft_trap_status
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic netAddrFault,
	input wire logic nvmAddrFault,
	input wire logic dmaAddrFault,
	input wire logic loopStackOverflow,
	input wire logic auxClockLockLoss,
	input wire logic eccDoubleError,
	input wire logic softHardTrap,
	input wire logic oscFailReq,
	input wire logic addrErrReq,
	input wire logic stackErrReq,
	input wire logic mathErrReq,
	input wire logic [15:0] irqPending,
	input wire logic interruptAcknowledge,
	input wire logic [3:0] ackLevel,
	output logic [7:0] encodedVector,
	output logic vectorPending
);

	// =====================================================
	// Bus decode
	logic setupRead;
	logic accessWrite;
	logic hitSoft;
	logic hitHard;
	logic hitStatus;
	logic hitCtrl;
	logic hitAny;

	always_comb
	begin
		hitSoft = (paddr == trap_status_pkg::SOFT_TRAP_FLAGS_OFS);
		hitHard = (paddr == trap_status_pkg::HARD_TRAP_FLAGS_OFS);
		hitStatus = (paddr == trap_status_pkg::VECTOR_STATUS_OFS);
		hitCtrl = (paddr == trap_status_pkg::VECTOR_CTRL_OFS);
		hitAny = hitSoft | hitHard | hitStatus | hitCtrl;
		setupRead = psel & ~penable & ~pwrite;
		accessWrite = psel & penable & pwrite & hitAny;
		// Zero wait states; unmapped words answer with an error
		pready = psel & penable;
		pslverr = psel & penable & ~hitAny;
	end

	// =====================================================
	// Trap flags
	logic [15:0] softFlags_q;
	logic [15:0] softFlags_d;
	logic [15:0] hardFlags_q;
	logic [15:0] hardFlags_d;
	logic [15:0] softEvents;
	logic [15:0] hardEvents;

	always_comb
	begin
		softEvents = 16'h0000;
		softEvents[trap_status_pkg::NET_ADDR_FAULT_BIT] = netAddrFault; // R1
		softEvents[trap_status_pkg::NVM_ADDR_FAULT_BIT] = nvmAddrFault; // R2
		softEvents[trap_status_pkg::DMA_ADDR_FAULT_BIT] = dmaAddrFault; // R3
		softEvents[trap_status_pkg::LOOP_OVERFLOW_BIT] = loopStackOverflow; // R4
		softEvents[trap_status_pkg::AUX_LOCK_LOSS_BIT] = auxClockLockLoss; // R5
		hardEvents = 16'h0000;
		hardEvents[trap_status_pkg::ECC_DOUBLE_BIT] = eccDoubleError; // R7
		hardEvents[trap_status_pkg::SOFT_MADE_HARD_BIT] = softHardTrap; // R8
		softFlags_d = softFlags_q;
		hardFlags_d = hardFlags_q;
		// Writing zero clears, writing one keeps; a same-cycle event still sets
		if (accessWrite && hitSoft)
		begin
			softFlags_d = softFlags_q & pwdata[15:0]; // R15
		end
		if (accessWrite && hitHard)
		begin
			hardFlags_d = hardFlags_q & pwdata[15:0]; // R15
		end
		softFlags_d = (softFlags_d | softEvents) & trap_status_pkg::SOFT_IMPL_MASK; // R6
		hardFlags_d = (hardFlags_d | hardEvents) & trap_status_pkg::HARD_IMPL_MASK; // R9
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			softFlags_q <= trap_status_pkg::FLAGS_RESET;
			hardFlags_q <= trap_status_pkg::FLAGS_RESET;
		end
		else
		begin
			softFlags_q <= softFlags_d;
			hardFlags_q <= hardFlags_d;
		end
	end

	// =====================================================
	// Vector encoding tree
	// Lowest code wins; any flag raises the generic soft or hard trap
	logic [7:0] encVec;
	logic encValid;

	always_comb
	begin
		encVec = trap_status_pkg::VECTOR_RESET;
		encValid = 1'b1;
		if (oscFailReq)
		begin
			encVec = trap_status_pkg::VEC_OSC_FAIL; // R13
		end
		else if (addrErrReq)
		begin
			encVec = trap_status_pkg::VEC_ADDR_ERR; // R13
		end
		else if (|hardFlags_q)
		begin
			encVec = trap_status_pkg::VEC_HARD_TRAP; // R13
		end
		else if (stackErrReq)
		begin
			encVec = trap_status_pkg::VEC_STACK_ERR; // R13
		end
		else if (mathErrReq)
		begin
			encVec = trap_status_pkg::VEC_MATH_ERR; // R13
		end
		else if (|softFlags_q)
		begin
			encVec = trap_status_pkg::VEC_SOFT_TRAP; // R13
		end
		else
		begin
			encValid = 1'b0;
			// Highest index first so the lowest wins; tops out at 23, never 255
			for (int i = trap_status_pkg::IRQ_COUNT - 1; i >= 0; i--)
			begin
				if (irqPending[i])
				begin
					encVec = trap_status_pkg::VEC_IRQ_BASE + 8'(i); // R13 R14
					encValid = 1'b1;
				end
			end
		end
	end

	// =====================================================
	// Acknowledge capture and live select
	logic liveSelect_q;
	logic liveSelect_d;
	logic [7:0] heldVector_q;
	logic [7:0] heldVector_d;
	logic [3:0] newLevel_q;
	logic [3:0] newLevel_d;
	logic [7:0] shownVector;

	always_comb
	begin
		liveSelect_d = liveSelect_q;
		heldVector_d = heldVector_q;
		newLevel_d = newLevel_q;
		if (accessWrite && hitCtrl)
		begin
			liveSelect_d = pwdata[trap_status_pkg::CTRL_LIVE_BIT];
		end
		if (interruptAcknowledge)
		begin
			heldVector_d = encVec; // R11
			newLevel_d = ackLevel; // R12
		end
		shownVector = liveSelect_q ? encVec : heldVector_q; // R10 R11
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			liveSelect_q <= 1'b0;
			heldVector_q <= trap_status_pkg::VECTOR_RESET; // R16
			newLevel_q <= trap_status_pkg::LEVEL_RESET; // R16
		end
		else
		begin
			liveSelect_q <= liveSelect_d;
			heldVector_q <= heldVector_d;
			newLevel_q <= newLevel_d;
		end
	end

	// =====================================================
	// Read data, loaded in the setup phase so it stands through access
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic [15:0] statusWord;

	always_comb
	begin
		statusWord = 16'h0000;
		statusWord[trap_status_pkg::LIVE_SELECT_BIT] = liveSelect_q;
		statusWord[trap_status_pkg::LEVEL_LSB +: 4] = newLevel_q; // R12
		statusWord[7:0] = shownVector;
		prdata_d = prdata_q;
		if (setupRead)
		begin
			prdata_d = 32'h0000_0000;
			if (hitSoft)
			begin
				prdata_d[15:0] = softFlags_q;
			end
			else if (hitHard)
			begin
				prdata_d[15:0] = hardFlags_q;
			end
			else if (hitStatus)
			begin
				prdata_d[15:0] = statusWord; // R16
			end
			else if (hitCtrl)
			begin
				prdata_d[trap_status_pkg::CTRL_LIVE_BIT] = liveSelect_q;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			prdata_q <= 32'h0000_0000;
			encodedVector <= trap_status_pkg::VECTOR_RESET;
			vectorPending <= 1'b0;
		end
		else
		begin
			prdata_q <= prdata_d;
			encodedVector <= encVec;
			vectorPending <= encValid;
		end
	end

	assign prdata = prdata_q;

	// =====================================================
	// Checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	net_flag_set_a: assert property (netAddrFault |=> softFlags_q[9]) // R1
		else $error("network address fault flag not set");
	nvm_flag_set_a: assert property (nvmAddrFault |=> softFlags_q[8]) // R2
		else $error("memory address fault flag not set");
	dma_flag_set_a: assert property (dmaAddrFault |=> softFlags_q[5]) // R3
		else $error("dma address fault flag not set");
	loop_flag_set_a: assert property (loopStackOverflow |=> softFlags_q[4]) // R4
		else $error("loop overflow flag not set");
	aux_flag_set_a: assert property (auxClockLockLoss |=> softFlags_q[0]) // R5
		else $error("lock loss flag not set");
	soft_reserved_zero_a: assert property ((softFlags_q & 16'hFCCE) == 16'h0000) // R6
		else $error("soft reserved bits not zero");
	ecc_flag_set_a: assert property (eccDoubleError |=> hardFlags_q[1]) // R7
		else $error("ecc flag not set");
	hard_soft_set_a: assert property (softHardTrap |=> hardFlags_q[0]) // R8
		else $error("software hard trap flag not set");
	hard_reserved_zero_a: assert property (hardFlags_q[15:2] == 14'h0000) // R9
		else $error("hard reserved bits not zero");
	live_vector_a: assert property (liveSelect_q && setupRead && hitStatus
		|=> prdata_q[7:0] == $past(encVec)) // R10
		else $error("live vector not shown");
	held_vector_a: assert property (interruptAcknowledge ##1 (!interruptAcknowledge)[*2]
		|-> heldVector_q == $past(encVec, 3)) // R11
		else $error("held vector changed without acknowledge");
	level_capture_a: assert property (interruptAcknowledge |=> newLevel_q == $past(ackLevel)) // R12
		else $error("new priority level not captured");
	soft_code_a: assert property (!oscFailReq && !addrErrReq && !stackErrReq && !mathErrReq
		&& hardFlags_q == 16'h0000 && softFlags_q != 16'h0000
		|=> encodedVector == 8'h06) // R13
		else $error("generic soft trap code wrong");
	reserved_code_a: assert property (encVec != 8'h05 && encVec != 8'h07
		&& encVec != 8'hFF) // R14
		else $error("reserved vector code produced");
	flag_sticky_a: assert property (softFlags_q[9] && !(accessWrite && hitSoft)
		|=> softFlags_q[9]) // R15
		else $error("flag cleared without software write");
	status_write_a: assert property (accessWrite && hitStatus && !interruptAcknowledge
		|=> $stable(newLevel_q) && $stable(heldVector_q)) // R16
		else $error("status register changed by write");

endmodule

// >>> test/cpu_trap_model.sv
`timescale 1ns/100ps

// ==========================================
// CPU core and trap sources stand-in
module cpu_trap_model
(
	input wire logic mclk,
	output logic [4:0] softEv,
	output logic [1:0] hardEv,
	output logic [3:0] trapReq,
	output logic [15:0] irqLines,
	output logic ackPulse,
	output logic [3:0] ackLvl
);
	initial
	begin
		softEv = 5'h00;
		hardEv = 2'h0;
		trapReq = 4'h0;
		irqLines = 16'h0000;
		ackPulse = 1'b0;
		ackLvl = 4'h0;
	end

	// One-cycle events; a held level would keep flags set
	task automatic pulse(input logic [6:0] ev);
		@(posedge mclk);
		{hardEv, softEv} <= ev;
		@(posedge mclk);
		{hardEv, softEv} <= 7'h00;
	endtask

	task automatic setLevels(input logic [3:0] rq, input logic [15:0] iq);
		@(posedge mclk);
		trapReq <= rq;
		irqLines <= iq;
	endtask

	task automatic ack(input logic [3:0] lvl);
		@(posedge mclk);
		ackPulse <= 1'b1;
		ackLvl <= lvl;
		@(posedge mclk);
		ackPulse <= 1'b0;
	endtask
endmodule

// >>> test/tb_soft_trap_status_and_vector_capture.sv
`timescale 1ns/100ps

`define CHK(n, e, g) \
	begin numChecks++; if ((g) !== (e)) begin failures++; \
	$display("BAD %s exp %h got %h", n, e, g); end end

module tb_soft_trap_status_and_vector_capture;
	localparam logic [7:0] aSoft = trap_status_pkg::SOFT_TRAP_FLAGS_OFS;
	localparam logic [7:0] aHard = trap_status_pkg::HARD_TRAP_FLAGS_OFS;
	localparam logic [7:0] aStat = trap_status_pkg::VECTOR_STATUS_OFS;
	localparam logic [7:0] aCtrl = trap_status_pkg::VECTOR_CTRL_OFS;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [4:0] softEv;
	logic [1:0] hardEv;
	logic [3:0] trapReq;
	logic [15:0] irqLines;
	logic ackPulse;
	logic [3:0] ackLvl;
	logic [7:0] encodedVector;
	logic vectorPending;
	int failures = 0;
	int numChecks = 0;
	int cycles = 0;

	always #4 mclk = ~mclk;

	cpu_trap_model u_cpu (.mclk(mclk), .softEv(softEv), .hardEv(hardEv),
		.trapReq(trapReq), .irqLines(irqLines), .ackPulse(ackPulse), .ackLvl(ackLvl));

	soft_trap_status u_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .netAddrFault(softEv[4]),
		.nvmAddrFault(softEv[3]), .dmaAddrFault(softEv[2]),
		.loopStackOverflow(softEv[1]), .auxClockLockLoss(softEv[0]),
		.eccDoubleError(hardEv[1]), .softHardTrap(hardEv[0]),
		.oscFailReq(trapReq[0]), .addrErrReq(trapReq[1]), .stackErrReq(trapReq[2]),
		.mathErrReq(trapReq[3]), .irqPending(irqLines),
		.interruptAcknowledge(ackPulse), .ackLevel(ackLvl),
		.encodedVector(encodedVector), .vectorPending(vectorPending));

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic err);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic chkRd(input logic [7:0] a, input logic [31:0] x, input string n);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		`CHK(n, x, r)
	endtask

	task automatic test_soft();
		int pos[5] = '{9, 8, 5, 4, 0};
		for (int i = 0; i < 5; i++)
		begin
			u_cpu.pulse(7'(5'h10 >> i));
			chkRd(aSoft, 32'h1 << pos[i], "softFlag");
			wr(aSoft, 32'h0000_0000);
		end
		u_cpu.pulse(7'h1F);
		wr(aSoft, 32'hFFFF_FFFF);
		chkRd(aSoft, {16'h0000, trap_status_pkg::SOFT_IMPL_MASK}, "softKeep");
		wr(aSoft, 32'h0000_0000);
		chkRd(aSoft, 32'h0000_0000, "softClr");
	endtask

	task automatic test_hard();
		u_cpu.pulse(7'h40);
		chkRd(aHard, 32'h0000_0002, "eccFlag");
		wr(aHard, 32'h0000_0000);
		u_cpu.pulse(7'h20);
		chkRd(aHard, 32'h0000_0001, "swHard");
		u_cpu.pulse(7'h60);
		wr(aHard, 32'hFFFF_FFFF);
		chkRd(aHard, 32'h0000_0003, "hardKeep");
		wr(aHard, 32'h0000_0000);
	endtask

	// Background irq15 makes every case a priority contest
	task automatic test_live();
		logic [3:0] rq[8] = '{4'h1, 4'h2, 4'h0, 4'h4, 4'h8, 4'h0, 4'h0, 4'h0};
		logic [6:0] ev[8] = '{7'h00, 7'h00, 7'h20, 7'h00, 7'h00, 7'h01, 7'h00, 7'h00};
		logic [7:0] vec[8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h09};
		wr(aCtrl, 32'h0000_0001);
		chkRd(aCtrl, 32'h0000_0001, "liveSel");
		for (int i = 0; i < 8; i++)
		begin
			u_cpu.setLevels(rq[i], 16'h8000 | (16'(i > 5) << (i - 6)));
			u_cpu.pulse(ev[i]);
			repeat (3) @(posedge mclk);
			`CHK("vecOut", vec[i], encodedVector)
			`CHK("pendOn", 1'b1, vectorPending)
			chkRd(aStat, {16'h0000, 8'h20, vec[i]}, "liveVec");
			wr(aSoft, 32'h0000_0000);
			wr(aHard, 32'h0000_0000);
		end
	endtask

	task automatic test_latch();
		logic [31:0] r;
		logic e;
		wr(aCtrl, 32'h0000_0000);
		u_cpu.setLevels(4'h0, 16'h0002);
		repeat (3) @(posedge mclk);
		u_cpu.ack(4'hF);
		u_cpu.setLevels(4'h1, 16'h0000);
		repeat (3) @(posedge mclk);
		chkRd(aStat, 32'h0000_0F09, "heldVec");
		wr(aStat, 32'hFFFF_FFFF);
		chkRd(aStat, 32'h0000_0F09, "statWr");
		u_cpu.ack(4'h0);
		chkRd(aStat, 32'h0000_0000, "nextAck");
		apb(1'b0, 8'h10, 32'h0000_0000, r, e);
		`CHK("unmapErr", 1'b1, e)
		`CHK("unmapData", 32'h0000_0000, r)
	endtask

	task automatic test_done();
		if (failures == 0 && numChecks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Ceiling well above the few hundred cycles the tests need
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			test_done();
		end
	end

	initial
	begin
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		chkRd(aStat, 32'h0000_0000, "statRst");
		`CHK("pendIdle", 1'b0, vectorPending)
		chkRd(aSoft, 32'h0000_0000, "softRst");
		test_soft();
		test_hard();
		test_live();
		test_latch();
		test_done();
	end
endmodule
